/* File: hw/trf_pkg.sv */
// Constants, types and settings of the torque reference filter chain.
// Function
// RULE1: lag stage then filter stages, in series
// RULE2: lag time constant 0..65535, 0.01 ms, default 100
// RULE3: low-pass frequency 100..5000 Hz, default 5000
// RULE4: low-pass frequency 5000 bypasses the low-pass
// RULE5: low-pass Q 50..100, 0.01 steps, default 50
// RULE6: select digit 0 equal 1 enables notch one
// RULE7: select digit 2 equal 1 enables notch two
// RULE8: notch frequencies 50..5000 Hz, default 5000
// RULE9: notch Q 50..1000, 0.01 steps, default 70
// RULE10: notch one depth 0..1000, 0.001 steps
// RULE11: notch two depth 0..1000, 0.001 steps
// RULE12: enabled notch attenuates around its frequency
// RULE13: higher Q gives narrower, sharper notch
// RULE14: software keeps lag below loop limit
// RULE15: notch four times above loop response
// RULE16: change notch frequency only when stopped
package trf_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADR_LAG = 8'h00;
	localparam logic [7:0] ADR_LPF = 8'h04;
	localparam logic [7:0] ADR_LPQ = 8'h08;
	localparam logic [7:0] ADR_SEL = 8'h0C;
	localparam logic [7:0] ADR_N1F = 8'h10;
	localparam logic [7:0] ADR_N1Q = 8'h14;
	localparam logic [7:0] ADR_N1D = 8'h18;
	localparam logic [7:0] ADR_N2F = 8'h1C;
	localparam logic [7:0] ADR_N2Q = 8'h20;
	localparam logic [7:0] ADR_N2D = 8'h24;
	localparam logic [7:0] ADR_STAT = 8'h28;
	// ****************************************
	// Reset values and ranges
	// ****************************************
	localparam logic [15:0] LAG_RST = 16'h0064;
	localparam logic [15:0] LAG_MIN = 16'h0000;
	localparam logic [15:0] LAG_MAX = 16'hFFFF;
	localparam logic [15:0] LPF_MIN = 16'h0064;
	localparam logic [15:0] LPF_MAX = 16'h1388;
	localparam logic [15:0] LPQ_MIN = 16'h0032;
	localparam logic [15:0] LPQ_MAX = 16'h0064;
	localparam logic [15:0] NF_MIN = 16'h0032;
	localparam logic [15:0] NF_MAX = 16'h1388;
	localparam logic [15:0] NQ_RST = 16'h0046;
	localparam logic [15:0] NQ_MIN = 16'h0032;
	localparam logic [15:0] NQ_MAX = 16'h03E8;
	localparam logic [15:0] ND_MIN = 16'h0000;
	localparam logic [15:0] ND_MAX = 16'h03E8;
	localparam logic [15:0] SEL_RST = 16'h0000;
	localparam logic [3:0] SEL_ON = 4'h1;
	// ****************************************
	// Arithmetic scaling
	// ****************************************
	// Samples arrive at 40 kHz, one each 25 us, or 2.5 lag units.
	localparam int FS_HZ = 40000;
	localparam logic [7:0] F_K = 8'hA5;
	localparam logic [31:0] LAG_NUM = 32'h0005_0000;
	localparam logic [17:0] LAG_DEN0 = 18'h00005;
	localparam logic [31:0] Q_NUM = 32'h0019_0000;
	localparam logic [7:0] DEPTH_K = 8'h41;
	localparam logic [16:0] ALPHA_ONE = 17'h10000;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_LAG = 6'h02,
		S_LP = 6'h04,
		S_N1 = 6'h08,
		S_N2 = 6'h10,
		S_OUT = 6'h20
	} trf_st_t;
	typedef struct packed {
		logic [15:0] lag;
		logic [15:0] lpf;
		logic [15:0] lpq;
		logic [15:0] sel;
		logic [15:0] n1f;
		logic [15:0] n1q;
		logic [15:0] n1d;
		logic [15:0] n2f;
		logic [15:0] n2q;
		logic [15:0] n2d;
		logic ack;
		logic [31:0] dat;
		logic [16:0] alpha;
		logic [2:0][15:0] dq;
		logic [1:0] ci;
		logic cw;
		logic cok;
		trf_st_t st;
		logic signed [17:0] x;
		logic signed [17:0] lag_y;
		logic [2:0][17:0] low;
		logic [2:0][17:0] band;
		logic [15:0] out;
		logic ovalid;
	} trf_top_t;
	function automatic logic [15:0] trf_clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : trf_clamp
endpackage : trf_pkg

/* File: hw/trf_svf_if.sv */
// Carrier between the sequencer and the shared filter datapath.
`timescale 1ns/1ns
interface trf_svf_if;
	logic signed [17:0] x;
	logic signed [17:0] low;
	logic signed [17:0] band;
	logic [15:0] f;
	logic [15:0] d;
	logic signed [17:0] low_n;
	logic signed [17:0] band_n;
	logic signed [17:0] notch;
	modport calc(input x, low, band, f, d,
		output low_n, band_n, notch);
	modport user(output x, low, band, f, d,
		input low_n, band_n, notch);
endinterface : trf_svf_if

/* File: hw/trf_svf.sv */
// One step of a state-variable second-order section.
`timescale 1ns/1ns
module trf_svf (
	// Datapath
	trf_svf_if.calc p
);
	logic signed [34:0] pf1;
	logic signed [34:0] pd;
	logic signed [34:0] pf2;
	logic signed [17:0] high;
	always_comb begin
		pf1 = p.band * $signed({1'b0, p.f});
		p.low_n = p.low + pf1[33:16];
		// Damping is one over Q, so a high Q leaves a narrow notch.
		pd = p.band * $signed({1'b0, p.d}); // RULE13
		high = p.x - p.low_n - pd[31:14];
		pf2 = high * $signed({1'b0, p.f});
		p.band_n = p.band + pf2[33:16];
		p.notch = high + p.low_n; // RULE12
	end
endmodule : trf_svf

/* File: hw/trf_div.sv */
// Serial restoring divider for the coefficient updates.
`timescale 1ns/1ns
module trf_div import trf_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Operands
	input wire logic start_i,
	input wire logic [31:0] num_i,
	input wire logic [17:0] den_i,
	// Result
	output logic done_o,
	output logic [16:0] quot_o
);
	typedef struct packed {
		logic run;
		logic [5:0] cnt;
		logic [18:0] rem;
		logic [31:0] n;
		logic [17:0] den;
		logic [31:0] q;
		logic done;
		logic [16:0] quot;
	} trf_div_t;
	trf_div_t s;
	trf_div_t next_s;
	logic [18:0] rem2;
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		rem2 = {s.rem[17:0], s.n[31]};
		if (start_i && !s.run) begin
			next_s.run = 1'b1;
			next_s.cnt = 6'h00;
			next_s.rem = 19'h00000;
			next_s.n = num_i;
			next_s.den = den_i;
			next_s.q = 32'h0000_0000;
		end else if (s.run) begin
			next_s.n = {s.n[30:0], 1'b0};
			next_s.cnt = s.cnt + 6'h01;
			if (rem2 >= {1'b0, s.den}) begin
				next_s.rem = rem2 - {1'b0, s.den};
				next_s.q = {s.q[30:0], 1'b1};
			end else begin
				next_s.rem = rem2;
				next_s.q = {s.q[30:0], 1'b0};
			end
			if (s.cnt == DIV_STEPS - 6'h01) begin
				next_s.run = 1'b0;
				next_s.done = 1'b1;
				// Saturate rather than wrap on small divisors.
				if (next_s.q[31:17] != 15'h0000) begin
					next_s.quot = 17'h1FFFF;
				end else begin
					next_s.quot = next_s.q[16:0];
				end
			end
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign done_o = s.done;
	assign quot_o = s.quot;
endmodule : trf_div

/* File: hw/trf_top.sv */
// Torque reference filter chain with its Wishbone register slave.
`timescale 1ns/1ns
module trf_top import trf_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Torque command from the speed loop
	input wire logic signed [15:0] sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	// Filtered torque to the current loop
	output logic signed [15:0] torque_o,
	output logic torque_valid_o
);
	// ****************************************
	// State and helpers
	// ****************************************
	trf_top_t s;
	trf_top_t next_s;
	trf_svf_if svf();
	logic div_start;
	logic div_done;
	logic [16:0] div_quot;
	logic [31:0] div_num;
	logic [17:0] div_den;
	logic [31:0] rd_val;
	logic [2:0][15:0] frq;
	logic [2:0][15:0] fco;
	logic [2:0][23:0] fprod;
	logic [1:0] idx;
	logic req;
	logic [15:0] wv;
	logic signed [17:0] lag_d;
	logic signed [35:0] lag_p;
	logic signed [17:0] mix_d;
	logic signed [34:0] mix_p;
	logic [15:0] dk;
	logic [15:0] depth;
	logic n1_on;
	logic n2_on;

	trf_svf u_svf (
		.p(svf.calc)
	);

	trf_div u_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(div_start),
		.num_i(div_num),
		.den_i(div_den),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// ****************************************
	// Coefficients
	// ****************************************
	// Frequency coefficients follow the settings at once; lag and damping
	// coefficients are redivided, so a write is heard within two passes of the background loop.
	assign frq[0] = s.lpf;
	assign frq[1] = s.n1f;
	assign frq[2] = s.n2f;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_fco
			assign fprod[gi] = frq[gi] * F_K;
			assign fco[gi] = fprod[gi][19:4];
		end
	endgenerate

	always_comb begin
		div_num = Q_NUM;
		div_den = {2'b00, s.lpq};
		case (s.ci)
			2'h0: begin
				div_num = LAG_NUM;
				div_den = {1'b0, s.lag, 1'b0} + LAG_DEN0; // RULE2
			end
			2'h1: begin
				div_den = {2'b00, s.lpq}; // RULE5
			end
			2'h2: begin
				div_den = {2'b00, s.n1q}; // RULE9
			end
			default: begin
				div_den = {2'b00, s.n2q}; // RULE9
			end
		endcase
	end

	// ****************************************
	// Register read
	// ****************************************
	always_comb begin
		rd_val = 32'h0000_0000;
		case (wb_adr_i)
			ADR_LAG: rd_val[15:0] = s.lag;
			ADR_LPF: rd_val[15:0] = s.lpf;
			ADR_LPQ: rd_val[15:0] = s.lpq;
			ADR_SEL: rd_val[15:0] = s.sel;
			ADR_N1F: rd_val[15:0] = s.n1f;
			ADR_N1Q: rd_val[15:0] = s.n1q;
			ADR_N1D: rd_val[15:0] = s.n1d;
			ADR_N2F: rd_val[15:0] = s.n2f;
			ADR_N2Q: rd_val[15:0] = s.n2q;
			ADR_N2D: rd_val[15:0] = s.n2d;
			ADR_STAT: rd_val = {14'h0000, s.cok, s.st != S_IDLE, s.out};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Shared section datapath
	// ****************************************
	always_comb begin
		case (s.st)
			S_N1: idx = 2'h1;
			S_N2: idx = 2'h2;
			default: idx = 2'h0;
		endcase
	end
	assign svf.x = s.x;
	assign svf.low = s.low[idx];
	assign svf.band = s.band[idx];
	assign svf.f = fco[idx];
	assign svf.d = s.dq[idx];
	assign n1_on = s.sel[3:0] == SEL_ON; // RULE6
	assign n2_on = s.sel[11:8] == SEL_ON; // RULE7
	assign depth = (s.st == S_N2) ? s.n2d : s.n1d;
	assign dk = 16'(depth * DEPTH_K);
	// Depth zero keeps the full notch; full depth gives the input back.
	assign mix_d = s.x - svf.notch;
	assign mix_p = mix_d * $signed({1'b0, dk}); // RULE10 RULE11
	assign lag_d = s.x - s.lag_y;
	assign lag_p = lag_d * $signed({1'b0, s.alpha}); // RULE2
	assign req = wb_cyc_i && wb_stb_i;
	assign wv = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
		wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.ovalid = 1'b0;
		div_start = 1'b0;
		if (req && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.dat = rd_val;
		end
		// A write lands on the edge where the master sees ack.
		if (req && s.ack && wb_we_i && wb_sel_i[1:0] == 2'b11) begin
			case (wb_adr_i)
				ADR_LAG: next_s.lag = trf_clamp(wv, LAG_MIN, LAG_MAX);
				ADR_LPF: next_s.lpf = trf_clamp(wv, LPF_MIN, LPF_MAX);
				ADR_LPQ: next_s.lpq = trf_clamp(wv, LPQ_MIN, LPQ_MAX);
				ADR_SEL: next_s.sel = wv;
				ADR_N1F: next_s.n1f = trf_clamp(wv, NF_MIN, NF_MAX);
				ADR_N1Q: next_s.n1q = trf_clamp(wv, NQ_MIN, NQ_MAX);
				ADR_N1D: next_s.n1d = trf_clamp(wv, ND_MIN, ND_MAX);
				ADR_N2F: next_s.n2f = trf_clamp(wv, NF_MIN, NF_MAX);
				ADR_N2Q: next_s.n2q = trf_clamp(wv, NQ_MIN, NQ_MAX);
				ADR_N2D: next_s.n2d = trf_clamp(wv, ND_MIN, ND_MAX);
				default: next_s.sel = s.sel;
			endcase
		end
		if (!s.cw) begin
			div_start = 1'b1;
			next_s.cw = 1'b1;
		end else if (div_done) begin
			next_s.cw = 1'b0;
			next_s.ci = s.ci + 2'h1;
			if (s.ci == 2'h0) begin
				next_s.alpha = div_quot;
			end else begin
				next_s.dq[2'(s.ci - 2'h1)] = div_quot[15:0];
			end
			if (s.ci == 2'h3) begin
				next_s.cok = 1'b1;
			end
		end
		case (s.st) // RULE1
			S_IDLE: begin
				if (sample_valid_i && s.cok) begin
					next_s.x = 18'(sample_i);
					next_s.st = S_LAG;
				end
			end
			S_LAG: begin
				next_s.lag_y = s.lag_y + lag_p[33:16];
				next_s.x = s.lag_y + lag_p[33:16];
				next_s.st = S_LP;
			end
			S_LP: begin
				if (s.lpf != LPF_MAX) begin // RULE4
					next_s.low[0] = svf.low_n; // RULE3
					next_s.band[0] = svf.band_n;
					next_s.x = svf.low_n;
				end
				next_s.st = S_N1;
			end
			S_N1: begin
				if (n1_on) begin // RULE6
					next_s.low[1] = svf.low_n;
					next_s.band[1] = svf.band_n; // RULE8
					next_s.x = svf.notch + mix_p[33:16]; // RULE10
				end
				next_s.st = S_N2;
			end
			S_N2: begin
				if (n2_on) begin // RULE7
					next_s.low[2] = svf.low_n;
					next_s.band[2] = svf.band_n; // RULE8
					next_s.x = svf.notch + mix_p[33:16]; // RULE11
				end
				next_s.st = S_OUT;
			end
			S_OUT: begin
				if (s.x > 18'sh07FFF) begin
					next_s.out = 16'h7FFF;
				end else if (s.x < -18'sh08000) begin
					next_s.out = 16'h8000;
				end else begin
					next_s.out = s.x[15:0];
				end
				next_s.ovalid = 1'b1;
				next_s.st = S_IDLE;
			end
			default: next_s.st = S_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.lag <= LAG_RST; // RULE2
			s.lpf <= LPF_MAX; // RULE3
			s.lpq <= LPQ_MIN; // RULE5
			s.sel <= SEL_RST;
			s.n1f <= NF_MAX; // RULE8
			s.n2f <= NF_MAX;
			s.n1q <= NQ_RST; // RULE9
			s.n2q <= NQ_RST;
			s.n1d <= ND_MIN; // RULE10
			s.n2d <= ND_MIN; // RULE11
			s.st <= S_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
	assign sample_ready_o = s.st == S_IDLE && s.cok;
	assign torque_o = s.out;
	assign torque_valid_o = s.ovalid;

	// ****************************************
	// Checks
	// ****************************************
	// The settling pass after reset is short, so the checks are not
	// held off beyond reset itself.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held longer than one cycle");

	ack_cause_a: assert property (
		$rose(wb_ack_o) |-> $past(req)
	) else $error("ack without a request");

	chain_time_a: assert property ( // RULE1
		(sample_valid_i && sample_ready_o) |-> ##6 torque_valid_o
	) else $error("filtered sample not out six cycles later");

	lag_pass_a: assert property ( // RULE2
		(s.st == S_LAG && s.alpha == ALPHA_ONE)
		|=> s.lag_y == $past(s.x)
	) else $error("zero lag constant did not pass sample");

	lp_range_a: assert property ( // RULE3
		s.lpf >= LPF_MIN && s.lpf <= LPF_MAX
	) else $error("low-pass frequency out of range");

	lp_bypass_a: assert property ( // RULE4
		(s.st == S_LP && s.lpf == LPF_MAX)
		|=> s.x == $past(s.x) && s.low[0] == $past(s.low[0])
	) else $error("low-pass not bypassed at top frequency");

	lpq_range_a: assert property ( // RULE5
		s.lpq >= LPQ_MIN && s.lpq <= LPQ_MAX
	) else $error("low-pass Q out of range");

	n1_bypass_a: assert property ( // RULE6
		(s.st == S_N1 && s.sel[3:0] != SEL_ON) |=> s.x == $past(s.x)
	) else $error("first notch not bypassed");

	n2_bypass_a: assert property ( // RULE7
		(s.st == S_N2 && s.sel[11:8] != SEL_ON) |=> s.x == $past(s.x)
	) else $error("second notch not bypassed");

	nf_range_a: assert property ( // RULE8
		s.n1f >= NF_MIN && s.n1f <= NF_MAX
		&& s.n2f >= NF_MIN && s.n2f <= NF_MAX
	) else $error("notch frequency out of range");

	nq_range_a: assert property ( // RULE9
		s.n1q >= NQ_MIN && s.n1q <= NQ_MAX
		&& s.n2q >= NQ_MIN && s.n2q <= NQ_MAX
	) else $error("notch Q out of range");

	depth_range_a: assert property ( // RULE10
		s.n1d <= ND_MAX && s.n2d <= ND_MAX
	) else $error("notch depth out of range");

	coef_loop_a: assert property (
		$rose(s.cw) |-> ##[1:40] div_done
	) else $error("coefficient division did not finish");
endmodule : trf_top

/* File: bench/trf_src.sv */
// Speed loop model that offers torque command samples to the filter chain.
`timescale 1ns/1ns
module trf_src (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Waveform control
	input wire logic run_i,
	input wire logic step_i,
	input wire logic [7:0] period_i,
	input wire logic [15:0] amp_i,
	input wire logic [3:0] gap_i,
	// Sample stream
	output logic signed [15:0] sample_o,
	output logic sample_valid_o,
	input wire logic sample_ready_i
);
	int idx;
	int wait_n;
	real ph;
	// ****************************************
	// Offer and hold
	// ****************************************
	// Outside an offer the line toggles, so a late sampler reads junk.
	always @(posedge clock_i) begin
		if (!rstn_i) begin
			sample_valid_o <= 1'b0;
			sample_o <= 16'h5A5A;
			idx <= 0;
			wait_n <= 0;
		end else if (sample_valid_o && sample_ready_i) begin
			sample_valid_o <= 1'b0;
			sample_o <= ~sample_o;
			idx <= idx + 1;
			wait_n <= int'(gap_i);
		end else if (!sample_valid_o && wait_n > 0) begin
			wait_n <= wait_n - 1;
			sample_o <= ~sample_o;
		end else if (!sample_valid_o && run_i) begin
			ph = 6.2831853 * idx / period_i;
			sample_valid_o <= 1'b1;
			sample_o <= step_i ? amp_i : 16'($rtoi($itor(amp_i) * $sin(ph)));
		end else if (!sample_valid_o) begin
			sample_o <= ~sample_o;
		end
	end
endmodule : trf_src

/* File: bench/test_trf_top.sv */
// Self-checking testbench of the torque reference filter chain.
`timescale 1ns/1ns
module test_trf_top import trf_pkg::*; ;
	logic clock_i, rstn_i, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic signed [15:0] smp, torque, exp_s;
	logic s_valid, s_ready, t_valid, run, stp;
	logic [7:0] per;
	logic [3:0] gap;
	logic [5:0] take_sr;
	logic [15:0] last_t;
	logic signed [15:0] take_q[$];
	logic [15:0] dflt[10];
	logic [7:0] ca[14];
	logic [15:0] cw[14];
	logic [15:0] ce[14];
	int n_mismatch, check_count, n_out, peak, settle, mag;
	bit exact;
	trf_top i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .sample_i(smp), .sample_valid_i(s_valid),
		.sample_ready_o(s_ready), .torque_o(torque),
		.torque_valid_o(t_valid));
	trf_src i_src (.clock_i(clock_i), .rstn_i(rstn_i), .run_i(run),
		.step_i(stp), .period_i(per), .amp_i(16'h2710), .gap_i(gap),
		.sample_o(smp), .sample_valid_o(s_valid),
		.sample_ready_i(s_ready));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// ****************************************
	// Checks and bus tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic timed_out;
		n_mismatch++;
		$display("[ERR] %0t wait limit reached", $time);
		tally_and_finish();
	endtask : timed_out
	// The master holds every request signal until it samples ack high.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_wdat <= d;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 64);
		if (n >= 64) begin
			timed_out();
		end
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 4'hF, 32'h0);
		check(rd, {16'h0, e}, "register read");
	endtask : rchk
	// ****************************************
	// Stream monitor and scenarios
	// ****************************************
	always @(posedge clock_i) begin
		take_sr <= rstn_i ? {take_sr[4:0], s_valid & s_ready} : 6'h00;
		if (s_valid === 1'b1 && s_ready === 1'b1) begin
			take_q.push_back(smp);
		end
		if (t_valid === 1'b1 || take_sr[5] === 1'b1) begin
			check(32'(t_valid), 32'(take_sr[5]), "latency");
		end
		if (t_valid === 1'b1) begin
			check(32'(take_q.size() > 0), 32'h1, "output without input");
			exp_s = take_q.size() > 0 ? take_q.pop_front() : 16'h0000;
			n_out++;
			last_t = torque;
			mag = torque < 0 ? -int'(torque) : int'(torque);
			if (exact) begin
				check(32'(torque), 32'(exp_s), "pass-through");
			end
			if (n_out > settle && mag > peak) begin
				peak = mag;
			end
		end
	end
	// Every run starts from reset, so no filter state leaks between runs.
	task automatic scen(input logic [15:0] lag, lpf, sl, q, d1, d2,
		input logic [7:0] p, input logic st, input logic [3:0] g,
		input bit ex, input int lo, input int hi);
		logic [15:0] c[10];
		int n;
		c = '{lag, lpf, LPQ_MIN, sl, 16'h03E8, q, d1, 16'h03E8, q, d2};
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			wb(1'b1, 8'(4 * i), 4'hF, {16'h0, c[i]});
		end
		repeat (200) @(posedge clock_i);
		exact = ex;
		settle = st ? 0 : 200;
		n_out = 0;
		peak = 0;
		run <= 1'b1;
		stp <= st;
		per <= p;
		gap <= g;
		n = 0;
		while (n_out < (st ? 20 : 320) && n < 8000) begin
			@(posedge clock_i);
			n++;
		end
		run <= 1'b0;
		if (n >= 8000) begin
			timed_out();
		end
		repeat (20) @(posedge clock_i);
		wb(1'b0, ADR_STAT, 4'hF, 32'h0);
		check(rd, {14'h0000, 2'b10, last_t}, "status");
		check(32'(peak >= lo && peak <= hi), 32'h1, "output amplitude");
	endtask : scen
	initial begin
		rstn_i = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		run = 1'b0;
		stp = 1'b0;
		per = 8'h28;
		gap = 4'h0;
		n_mismatch = 0;
		check_count = 0;
		dflt = '{LAG_RST, LPF_MAX, LPQ_MIN, SEL_RST, NF_MAX, NQ_RST, ND_MIN,
			NF_MAX, NQ_RST, ND_MIN};
		ca = '{ADR_LPF, ADR_LPF, ADR_LPF, ADR_LPQ, ADR_LPQ, ADR_N1F, ADR_N1F,
			ADR_N1Q, ADR_N1Q, ADR_N1D, ADR_N2F, ADR_N2Q, ADR_N2D, ADR_LAG};
		cw = '{16'h0000, 16'hFFFF, 16'h03E8, 16'h0000, 16'h0065, 16'h0031,
			16'h1389, 16'h0031, 16'h03E9, 16'h03E9, 16'h0000, 16'hFFFF,
			16'hFFFF, 16'hFFFF};
		ce = '{16'h0064, 16'h1388, 16'h03E8, 16'h0032, 16'h0064, 16'h0032,
			16'h1388, 16'h0032, 16'h03E8, 16'h03E8, 16'h0032, 16'h03E8,
			16'h03E8, 16'hFFFF};
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rchk(8'(4 * i), dflt[i]);
		end
		rchk(ADR_STAT, 16'h0000);
		for (int i = 0; i < 14; i++) begin
			wb(1'b1, ca[i], 4'hF, {16'h0, cw[i]});
			rchk(ca[i], ce[i]);
		end
		wb(1'b1, ADR_LAG, 4'hF, 32'hABCD_0007);
		rchk(ADR_LAG, 16'h0007);
		wb(1'b1, ADR_N2D, 4'hC, 32'h0000_0005);
		rchk(ADR_N2D, 16'h03E8);
		wb(1'b1, ADR_SEL, 4'hF, 32'h0000_0101);
		rchk(ADR_SEL, 16'h0101);
		wb(1'b1, 8'h2C, 4'hF, 32'h0000_1234);
		rchk(8'h2C, 16'h0000);
		scen(16'h0, LPF_MAX, 16'h0000, NQ_RST, 16'h0, 16'h0, 8'h28, 1'b0,
			4'h0, 1, 0, 32767);
		scen(16'h0, LPF_MAX, 16'h0202, NQ_RST, 16'h0, 16'h0, 8'h28, 1'b0,
			4'h3, 1, 0, 32767);
		scen(16'h0, LPF_MAX, 16'h0001, NQ_RST, 16'h0, 16'h3E8, 8'h28, 1'b0,
			4'h0, 0, 0, 2500);
		scen(16'h0, LPF_MAX, 16'h0100, NQ_RST, 16'h3E8, 16'h0, 8'h28, 1'b0,
			4'h0, 0, 0, 2500);
		scen(16'h0, LPF_MAX, 16'h0001, NQ_RST, 16'h3E8, 16'h0, 8'h28, 1'b0,
			4'h0, 0, 9000, 10500);
		scen(16'h0, LPF_MAX, 16'h0100, NQ_RST, 16'h0, 16'h3E8, 8'h28, 1'b0,
			4'h0, 0, 9000, 10500);
		scen(16'h0, LPF_MAX, 16'h0001, NQ_MIN, 16'h0, 16'h0, 8'h14, 1'b0,
			4'h0, 0, 0, 8000);
		scen(16'h0, LPF_MAX, 16'h0001, NQ_MAX, 16'h0, 16'h0, 8'h14, 1'b0,
			4'h0, 0, 8500, 10500);
		scen(16'h0, LPF_MIN, 16'h0000, NQ_RST, 16'h0, 16'h0, 8'h14, 1'b0,
			4'h0, 0, 0, 2500);
		scen(LAG_RST, LPF_MAX, 16'h0000, NQ_RST, 16'h0, 16'h0, 8'h28, 1'b1,
			4'h0, 0, 1000, 7500);
		tally_and_finish();
	end
endmodule : test_trf_top
